//--- logic/tmc_consts.svh
// Register offsets, field positions and reset values for the dual timer/counter
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ==========================================================
// Register map
`define TMC_AW 3
`define TMC_OFS_MODE 3'h0
`define TMC_OFS_CTRL 3'h1
`define TMC_OFS_LO_A 3'h2
`define TMC_OFS_HI_A 3'h3
`define TMC_OFS_LO_B 3'h4
`define TMC_OFS_HI_B 3'h5

// ==========================================================
// Field positions
`define TMC_MODE_B_LSB 4
`define TMC_MODE_A_LSB 0
`define TMC_CTRL_FLAG_B 7
`define TMC_CTRL_RUN_B 6
`define TMC_CTRL_FLAG_A 5
`define TMC_CTRL_RUN_A 4

// ==========================================================
// Reset values
`define TMC_RST_BYTE 8'h00
`define TMC_RST_BIT 1'b0

`endif

//--- logic/tmc_pkg.sv
// Types shared by the dual timer/counter
`default_nettype none
package tmc_pkg;

  // Operating modes in field order
  typedef enum logic [1:0] {TMC_M13, TMC_M16, TMC_M8R, TMC_SPLIT} tmc_mode_t;

  // One nibble of the mode register
  typedef struct packed {
    logic gate;
    logic cnt_sel;
    tmc_mode_t mode;
  } tmc_ctl_t;

  // Result of one count step
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } tmc_cnt_t;

endpackage : tmc_pkg
`default_nettype wire

//--- logic/tmc_pin_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================
  // Synchroniser chain; first stage feeds only the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : tmc_pin_sync
`default_nettype wire

//--- logic/tmc_edge_det.sv
// Machine-cycle sampler and falling-edge detector for an event input
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_det (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic srst_in,
  input wire logic mc_stb_in,
  input wire logic pin_in,
  output logic fall_out
);

  logic samp_q;
  logic prev_q;

  // ==========================================================
  // One sample per machine cycle; a level shorter than a cycle may be missed
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (srst_in) begin
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (mc_stb_in) begin
      samp_q <= pin_in;
      prev_q <= samp_q;
    end
  end

  // High sample then low sample; counted on the next strobe, two cycles in all
  assign fall_out = mc_stb_in & prev_q & ~samp_q;

endmodule : tmc_edge_det
`default_nettype wire

//--- logic/tmc_top.sv
// Dual timer/counter with four modes, register port and pin sampling
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_top
  import tmc_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic srst_in,
  input wire logic mc_stb_in,
  input wire logic [`TMC_AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic gate_pin_a_in,
  input wire logic gate_pin_b_in,
  input wire logic event_input_a_in,
  input wire logic event_input_b_in,
  input wire logic vec_ack_a_in,
  input wire logic vec_ack_b_in,
  output logic overflow_flag_a_out,
  output logic overflow_flag_b_out,
  output logic ovf_pulse_a_out,
  output logic ovf_pulse_b_out
);

  // ==========================================================
  // State
  logic [7:0] mode_q, mode_d;
  logic run_a_q, run_a_d;
  logic run_b_q, run_b_d;
  logic flag_a_q, flag_a_d;
  logic flag_b_q, flag_b_d;
  logic [7:0] lo_a_q, lo_a_d;
  logic [7:0] hi_a_q, hi_a_d;
  logic [7:0] lo_b_q, lo_b_d;
  logic [7:0] hi_b_q, hi_b_d;
  logic [7:0] rdata_q, rdata_d;
  logic pulse_a_q, pulse_a_d;
  logic pulse_b_q, pulse_b_d;

  // ==========================================================
  // Pin synchronisers and edge detectors
  logic [3:0] pins_s;
  logic gate_pin_a_s;
  logic gate_pin_b_s;
  logic fall_a;
  logic fall_b;

  tmc_pin_sync #(.W(4)) u_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in({gate_pin_b_in, gate_pin_a_in, event_input_b_in, event_input_a_in}),
    .sync_out(pins_s)
  );

  assign gate_pin_a_s = pins_s[2];
  assign gate_pin_b_s = pins_s[3];

  tmc_edge_det u_edge_a (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .srst_in(srst_in),
    .mc_stb_in(mc_stb_in),
    .pin_in(pins_s[0]),
    .fall_out(fall_a)
  );

  tmc_edge_det u_edge_b (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .srst_in(srst_in),
    .mc_stb_in(mc_stb_in),
    .pin_in(pins_s[1]),
    .fall_out(fall_b)
  );

  // ==========================================================
  // One count step for a byte pair in the given mode
  function automatic tmc_cnt_t tmc_step(
    input logic [7:0] lo,
    input logic [7:0] hi,
    input tmc_mode_t m
  );
    tmc_cnt_t r;
    logic [12:0] c13;
    logic [15:0] c16;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    c13 = {hi, lo[4:0]};
    c16 = {hi, lo};
    unique case (m)
      TMC_M13: begin
        // Upper three low-byte bits are left as they stand
        r.ovf = &c13;
        c13 = c13 + 13'h0001;
        r.hi = c13[12:5];
        r.lo = {lo[7:5], c13[4:0]};
      end
      TMC_M16: begin
        r.ovf = &c16;
        c16 = c16 + 16'h0001;
        r.hi = c16[15:8];
        r.lo = c16[7:0];
      end
      TMC_M8R: begin
        r.ovf = &lo;
        r.lo = (&lo) ? hi : lo + 8'h01;
      end
      TMC_SPLIT: begin
        // High byte is stepped elsewhere in the split case
        r.ovf = &lo;
        r.lo = lo + 8'h01;
      end
    endcase
    return r;
  endfunction : tmc_step

  // ==========================================================
  // Mode register fields
  tmc_ctl_t ctl_a;
  tmc_ctl_t ctl_b;
  logic split_a;

  assign ctl_a = tmc_ctl_t'(mode_q[`TMC_MODE_A_LSB +: 4]);
  assign ctl_b = tmc_ctl_t'(mode_q[`TMC_MODE_B_LSB +: 4]);
  assign split_a = (ctl_a.mode == TMC_SPLIT);

  // ==========================================================
  // Count enables; tick_a, tick_b and tick_ah are qualified by the machine-cycle strobe, en_a and en_b are not
  logic en_a;
  logic en_b;
  logic tick_a;
  logic tick_b;
  logic tick_ah;

  assign en_a = run_a_q & (~ctl_a.gate | gate_pin_a_s);
  assign en_b = run_b_q & (~ctl_b.gate | gate_pin_b_s);
  // Source: machine cycle or sampled falling edge
  assign tick_a = mc_stb_in & en_a & (ctl_a.cnt_sel ? fall_a : 1'b1);
  // Timer B in its own mode 3 is frozen, same as run bit low
  assign tick_b = mc_stb_in & en_b & (ctl_b.cnt_sel ? fall_b : 1'b1) &
                  (ctl_b.mode != TMC_SPLIT);
  // Split high byte: machine cycles only, started by timer B run bit
  assign tick_ah = mc_stb_in & split_a & run_b_q;

  tmc_cnt_t step_a;
  tmc_cnt_t step_b;
  logic ovf_a;
  logic ovf_b;
  logic ovf_ah;

  assign step_a = tmc_step(lo_a_q, hi_a_q, ctl_a.mode);
  assign step_b = tmc_step(lo_b_q, hi_b_q, ctl_b.mode);
  assign ovf_a = tick_a & step_a.ovf;
  assign ovf_b = tick_b & step_b.ovf;
  assign ovf_ah = tick_ah & (&hi_a_q);

  // ==========================================================
  // Register port decode
  logic wr_mode;
  logic wr_ctrl;
  logic wr_lo_a;
  logic wr_hi_a;
  logic wr_lo_b;
  logic wr_hi_b;
  logic [7:0] ctrl_view;
  logic [7:0] rd_mux;

  assign wr_mode = wr_in & (addr_in == `TMC_OFS_MODE);
  assign wr_ctrl = wr_in & (addr_in == `TMC_OFS_CTRL);
  assign wr_lo_a = wr_in & (addr_in == `TMC_OFS_LO_A);
  assign wr_hi_a = wr_in & (addr_in == `TMC_OFS_HI_A);
  assign wr_lo_b = wr_in & (addr_in == `TMC_OFS_LO_B);
  assign wr_hi_b = wr_in & (addr_in == `TMC_OFS_HI_B);

  // Low nibble of the control view reads zero
  assign ctrl_view = {flag_b_q, run_b_q, flag_a_q, run_a_q, 4'h0};

  // Unmapped offsets read zero
  assign rd_mux = (addr_in == `TMC_OFS_MODE) ? mode_q :
                  (addr_in == `TMC_OFS_CTRL) ? ctrl_view :
                  (addr_in == `TMC_OFS_LO_A) ? lo_a_q :
                  (addr_in == `TMC_OFS_HI_A) ? hi_a_q :
                  (addr_in == `TMC_OFS_LO_B) ? lo_b_q :
                  (addr_in == `TMC_OFS_HI_B) ? hi_b_q : 8'h00;

  // ==========================================================
  // Next-state logic: counting, then bus writes, then flag sets
  always_comb begin
    mode_d = mode_q;
    run_a_d = run_a_q;
    run_b_d = run_b_q;
    flag_a_d = flag_a_q;
    flag_b_d = flag_b_q;
    lo_a_d = lo_a_q;
    hi_a_d = hi_a_q;
    lo_b_d = lo_b_q;
    hi_b_d = hi_b_q;
    rdata_d = rd_in ? rd_mux : 8'h00;
    pulse_a_d = ovf_a;
    // Timer B overflow pulses even when its flag is lent out
    pulse_b_d = ovf_b;

    // Counting
    if (tick_a) begin
      lo_a_d = step_a.lo;
      hi_a_d = step_a.hi;
    end
    if (tick_ah) begin
      hi_a_d = hi_a_q + 8'h01;
    end
    if (tick_b) begin
      lo_b_d = step_b.lo;
      hi_b_d = step_b.hi;
    end

    // Software writes win over a count step in the same cycle
    if (wr_mode) begin
      mode_d = wdata_in;
    end
    if (wr_ctrl) begin
      // Run bits only gate counting; counts are not touched
      run_a_d = wdata_in[`TMC_CTRL_RUN_A];
      run_b_d = wdata_in[`TMC_CTRL_RUN_B];
      flag_a_d = wdata_in[`TMC_CTRL_FLAG_A];
      flag_b_d = wdata_in[`TMC_CTRL_FLAG_B];
    end
    if (wr_lo_a) begin
      lo_a_d = wdata_in;
    end
    if (wr_hi_a) begin
      hi_a_d = wdata_in;
    end
    if (wr_lo_b) begin
      lo_b_d = wdata_in;
    end
    if (wr_hi_b) begin
      hi_b_d = wdata_in;
    end

    // Vector acknowledge clears; a same-cycle overflow still sets
    if (vec_ack_a_in) begin
      flag_a_d = 1'b0;
    end
    if (vec_ack_b_in) begin
      flag_b_d = 1'b0;
    end
    if (ovf_a) begin
      flag_a_d = 1'b1;
    end
    // In split mode timer B flag belongs to the high byte of timer A
    if (split_a ? ovf_ah : ovf_b) begin
      flag_b_d = 1'b1;
    end

    // Block reset clears everything software can see
    if (srst_in) begin
      mode_d = `TMC_RST_BYTE;
      run_a_d = `TMC_RST_BIT;
      run_b_d = `TMC_RST_BIT;
      flag_a_d = `TMC_RST_BIT;
      flag_b_d = `TMC_RST_BIT;
      lo_a_d = `TMC_RST_BYTE;
      hi_a_d = `TMC_RST_BYTE;
      lo_b_d = `TMC_RST_BYTE;
      hi_b_d = `TMC_RST_BYTE;
      pulse_a_d = `TMC_RST_BIT;
      pulse_b_d = `TMC_RST_BIT;
    end
  end

  // ==========================================================
  // Control and flag registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_q <= `TMC_RST_BYTE;
      run_a_q <= `TMC_RST_BIT;
      run_b_q <= `TMC_RST_BIT;
      flag_a_q <= `TMC_RST_BIT;
      flag_b_q <= `TMC_RST_BIT;
    end else begin
      mode_q <= mode_d;
      run_a_q <= run_a_d;
      run_b_q <= run_b_d;
      flag_a_q <= flag_a_d;
      flag_b_q <= flag_b_d;
    end
  end

  // ==========================================================
  // Count bytes
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lo_a_q <= `TMC_RST_BYTE;
      hi_a_q <= `TMC_RST_BYTE;
      lo_b_q <= `TMC_RST_BYTE;
      hi_b_q <= `TMC_RST_BYTE;
    end else begin
      lo_a_q <= lo_a_d;
      hi_a_q <= hi_a_d;
      lo_b_q <= lo_b_d;
      hi_b_q <= hi_b_d;
    end
  end

  // ==========================================================
  // Read data and overflow pulses, registered
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= `TMC_RST_BYTE;
      pulse_a_q <= `TMC_RST_BIT;
      pulse_b_q <= `TMC_RST_BIT;
    end else begin
      rdata_q <= rdata_d;
      pulse_a_q <= pulse_a_d;
      pulse_b_q <= pulse_b_d;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_out = rdata_q;
  assign overflow_flag_a_out = flag_a_q;
  assign overflow_flag_b_out = flag_b_q;
  assign ovf_pulse_a_out = pulse_a_q;
  assign ovf_pulse_b_out = pulse_b_q;

endmodule : tmc_top
`default_nettype wire

//--- tb/tmc_top_chk.sv
// Port-level concurrent checks for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_chk (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic srst_in,
  input wire logic mc_stb_in,
  input wire logic [`TMC_AW-1:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic vec_ack_a_in,
  input wire logic overflow_flag_a_out,
  input wire logic overflow_flag_b_out,
  input wire logic ovf_pulse_a_out,
  input wire logic ovf_pulse_b_out
);
  // ==========================================================
  // Checks, one clock domain, off during async reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  ctl_read_a: assert property (rd_in && addr_in == `TMC_OFS_CTRL |=>
    rdata_out[`TMC_CTRL_FLAG_A] == $past(overflow_flag_a_out) && rdata_out[`TMC_CTRL_FLAG_B] ==
    $past(overflow_flag_b_out) && rdata_out[3:0] == 4'h0) else $error("control read mismatch");
  pulse_flag_a: assert property (ovf_pulse_a_out && !$past(vec_ack_a_in) && !$past(wr_in)
    |-> overflow_flag_a_out) else $error("pulse without flag");
  pulse_strobe_a: assert property ((ovf_pulse_a_out || ovf_pulse_b_out) |-> $past(mc_stb_in))
    else $error("pulse without strobe");
  flag_pulse_a: assert property ($rose(overflow_flag_a_out) && !$past(wr_in) && !srst_in
    |-> ovf_pulse_a_out) else $error("flag set without pulse");
  ack_clear_a: assert property (vec_ack_a_in && !mc_stb_in && !wr_in |=> !overflow_flag_a_out)
    else $error("acknowledge left flag set");
  flag_hold_a: assert property (!mc_stb_in && !wr_in && !overflow_flag_a_out |=> !overflow_flag_a_out)
    else $error("flag a set off strobe");
  flag_hold_b_a: assert property (!mc_stb_in && !wr_in && !overflow_flag_b_out |=> !overflow_flag_b_out)
    else $error("flag b set off strobe");
  srst_clear_a: assert property (srst_in |=> !overflow_flag_a_out && !overflow_flag_b_out &&
    !ovf_pulse_a_out && !ovf_pulse_b_out) else $error("block reset left state");
endmodule : tmc_chk
`default_nettype wire

//--- tb/tmc_top_tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tmc_top_tb;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic srst_in = 1'b0;
  logic mc_stb_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic gate_a = 1'b0;
  logic event_a = 1'b0;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic [7:0] rdata_out;
  logic flag_a, flag_b, pulse_a, pulse_b;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;

  // ==========================================================
  // Clock and design; timer B pins share A's drivers, B runs ungated in split tests
  initial forever #25 clk_in = ~clk_in;
  tmc_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .srst_in(srst_in), .mc_stb_in(mc_stb_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .gate_pin_a_in(gate_a), .gate_pin_b_in(gate_a), .event_input_a_in(event_a), .event_input_b_in(event_a),
    .vec_ack_a_in(ack_a), .vec_ack_b_in(ack_b), .overflow_flag_a_out(flag_a),
    .overflow_flag_b_out(flag_b), .ovf_pulse_a_out(pulse_a), .ovf_pulse_b_out(pulse_b));

  // ==========================================================
  // Bus and strobe drivers
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_out)
  endtask : rd

  // Idle cycle after each strobe shows non-strobe cycles never count
  task automatic stb(input int n);
    repeat (n) begin
      @(posedge clk_in);
      mc_stb_in <= 1'b1;
      @(posedge clk_in);
      mc_stb_in <= 1'b0;
    end
    #1;
  endtask : stb

  task automatic pins(input logic g, input logic ev);
    @(posedge clk_in);
    gate_a <= g;
    event_a <= ev; // Held many cycles
    repeat (3) @(posedge clk_in); // Synchroniser delay
  endtask : pins

  // ==========================================================
  // Scenarios
  task automatic t_mode0;
    wr(3'h3, 8'hff);
    wr(3'h2, 8'h1e);
    wr(3'h1, 8'h10);
    rd(3'h2, 8'h1e);
    stb(1);
    rd(3'h2, 8'h1f);
    stb(1);
    `CHK("flag_a", 1'b1, flag_a)
    `CHK("pulse_a", 1'b1, pulse_a)
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h00);
  endtask : t_mode0

  task automatic t_mode1_gate;
    wr(3'h1, 8'h10);
    wr(3'h0, 8'h09);
    wr(3'h2, 8'hff);
    wr(3'h3, 8'h12);
    stb(2);
    rd(3'h2, 8'hff);
    pins(1'b1, 1'b1);
    stb(1);
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h13);
    `CHK("flag_a", 1'b0, flag_a)
  endtask : t_mode1_gate

  task automatic t_reload;
    wr(3'h0, 8'h02);
    wr(3'h3, 8'hf0);
    wr(3'h2, 8'hff);
    stb(1);
    `CHK("flag_a", 1'b1, flag_a)
    rd(3'h2, 8'hf0);
    rd(3'h3, 8'hf0);
    stb(1);
    rd(3'h2, 8'hf1);
    @(posedge clk_in);
    ack_a <= 1'b1;
    @(posedge clk_in);
    ack_a <= 1'b0;
    #1;
    `CHK("flag_a", 1'b0, flag_a)
  endtask : t_reload

  task automatic t_counter;
    wr(3'h0, 8'h05);
    wr(3'h2, 8'h00);
    wr(3'h3, 8'h00);
    stb(2);
    pins(1'b0, 1'b0);
    stb(3);
    rd(3'h2, 8'h01);
    rd(3'h3, 8'h00);
  endtask : t_counter

  task automatic t_split;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h13);
    rd(3'h0, 8'h13);
    wr(3'h3, 8'hff);
    wr(3'h2, 8'hfe);
    wr(3'h4, 8'hff);
    wr(3'h5, 8'hff);
    wr(3'h1, 8'h50);
    stb(1);
    `CHK("pulse_b", 1'b1, pulse_b)
    `CHK("flag_b", 1'b1, flag_b)
    rd(3'h1, 8'hd0);
    rd(3'h4, 8'h00);
    stb(1);
    rd(3'h1, 8'hf0);
    wr(3'h0, 8'h33);
    stb(1);
    rd(3'h4, 8'h01);
    rd(3'h3, 8'h02);
    @(posedge clk_in);
    ack_b <= 1'b1;
    @(posedge clk_in);
    ack_b <= 1'b0;
    #1;
    `CHK("flag_b", 1'b0, flag_b)
  endtask : t_split

  task automatic t_srst;
    @(posedge clk_in);
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    `CHK("flag_a", 1'b0, flag_a)
    `CHK("flag_b", 1'b0, flag_b)
    for (int a = 0; a < 7; a++) rd(a[2:0], 8'h00);
  endtask : t_srst

  // ==========================================================
  // Verdict, hang guard and main sequence
  task automatic tally_and_finish;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int a = 0; a < 7; a++) rd(a[2:0], 8'h00);
    t_mode0();
    t_mode1_gate();
    t_reload();
    t_counter();
    t_split();
    t_srst();
    tally_and_finish();
  end
endmodule : tmc_top_tb

bind tmc_top tmc_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .srst_in(srst_in),
  .mc_stb_in(mc_stb_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .vec_ack_a_in(vec_ack_a_in), .overflow_flag_a_out(overflow_flag_a_out),
  .overflow_flag_b_out(overflow_flag_b_out), .ovf_pulse_a_out(ovf_pulse_a_out),
  .ovf_pulse_b_out(ovf_pulse_b_out));
`default_nettype wire
